// ---- core/blut_pkg.sv ----
// Shared constants and types for the bias lookup table access block.
// Assumes an 8-bit register port driven by a bus bridge on the same clock.
package blut_pkg;
    // ==========================================================
    // Register offsets (byte addresses on the register port)
    localparam logic [7:0] ADDR_ACCESS     = 8'h00;
    localparam logic [7:0] ADDR_TEMP_UPPER = 8'h01;
    localparam logic [7:0] ADDR_TEMP_LOWER = 8'h02;
    localparam logic [7:0] ADDR_CODEA_UP   = 8'h03;
    localparam logic [7:0] ADDR_CODEA_LO   = 8'h04;
    localparam logic [7:0] ADDR_CODEB_UP   = 8'h05;
    localparam logic [7:0] ADDR_CODEB_LO   = 8'h06;
    localparam logic [7:0] ADDR_OVR_SEL    = 8'h07;
    localparam logic [7:0] ADDR_OVR_T_UP   = 8'h08;
    localparam logic [7:0] ADDR_OVR_T_LO   = 8'h09;
    localparam logic [7:0] ADDR_BURN_CNT   = 8'h0c;
    localparam logic [7:0] ADDR_STATUS     = 8'h0d;
    localparam logic [7:0] ADDR_BURN_CMD   = 8'h0e;
    localparam logic [7:0] ADDR_TABLE      = 8'h10;
    localparam int         TABLE_BYTES     = 12;
    localparam logic [3:0] TABLE_LAST      = 4'hb;
    // Table byte indices
    localparam int IDX_BASE_A_UP = 0;
    localparam int IDX_BASE_A_LO = 1;
    localparam int IDX_BASE_B_UP = 2;
    localparam int IDX_BASE_B_LO = 3;
    localparam int IDX_SLOPE_A   = 4;
    localparam int IDX_SLOPE_B   = 8;
    // ==========================================================
    // Field positions
    localparam int BIT_POLARITY  = 7;
    localparam int BIT_BYPASS    = 6;
    localparam int BIT_OVR_TEMP  = 0;
    localparam int BIT_BURN_GO   = 0;
    localparam int BIT_BUSY      = 0;
    localparam int BIT_LOADED    = 1;
    localparam int SEG_SHIFT     = 5;
    // ==========================================================
    // Access levels and reset values
    localparam logic [1:0] READ_ONLY_ACCESS_LEVEL  = 2'd0;
    localparam logic [1:0] FULL_WRITE_ACCESS_LEVEL = 2'd2;
    localparam logic [7:0] BURN_CNT_MAX            = 8'hff;
    typedef logic [TABLE_BYTES-1:0][7:0] blut_table_t;
    // Unprogrammed store: base 0x800, slopes 0, polarity 0, bypass 0
    localparam blut_table_t NVM_DEFAULT = {8'h00, 8'h00, 8'h00, 8'h00,
                                           8'h00, 8'h00, 8'h00, 8'h00,
                                           8'h00, 8'h08, 8'h00, 8'h08};
    // ==========================================================
    // Types
    typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_BURN} blut_state_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } blut_bus_req_t;
    typedef struct packed {
        blut_state_t st;
        logic [3:0]  idx;
        logic [1:0]  level;
        blut_table_t wt;
        blut_table_t nvm;
        logic [7:0]  ovr_sel;
        logic [11:0] ovr_temp;
        logic [11:0] temp_s1;
        logic [11:0] temp_s2;
        logic [11:0] temp_s3;
        logic [11:0] temp_held;
        logic [1:0]  en_s1;
        logic [1:0]  en_s2;
        logic [11:0] code_a;
        logic [11:0] code_b;
        logic [11:0] temp_used;
        logic [7:0]  rdata;
        logic [7:0]  burn_cnt;
    } blut_regs_t;
endpackage

// ---- core/blut_core.sv ----
// Access gate, working lookup table, store copy that reset sets to NVM_DEFAULT, and signal path.
// Assumes the register port is on clk; sensor and enables come from pins.
`timescale 1ns/1ps
module blut_core
    import blut_pkg::*;
(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // Register port
    input  wire blut_bus_req_t bus_req,
    output logic [7:0]         reg_rdata,
    // Sensor and drive pins
    input  wire logic [11:0]   sensor_temp,
    input  wire logic          gate_drive_enable_a,
    input  wire logic          gate_drive_enable_b,
    output logic               gate_drive_out_a,
    output logic               gate_drive_out_b,
    // Codes toward the converters
    output logic [11:0]        dac_code_a,
    output logic [11:0]        dac_code_b
);
    // ==========================================================
    // Curve arithmetic
    // Piecewise line: full segments below the current one, plus a partial one
    function automatic logic [11:0] blut_curve(
        input logic [11:0] base,
        input logic [31:0] slopes,
        input logic        invert,
        input logic [11:0] t
    );
        logic [13:0] acc;
        logic [14:0] sum;
        logic [2:0]  seg;
        acc = 14'h0000;
        sum = 15'h0000;
        seg = t[11:9];
        for (int i = 0; i < 8; i++)
        begin
            if (3'(i) < seg)
            begin
                acc = acc + {5'h00, slopes[i*4 +: 4], 5'h00};
            end
            else if (3'(i) == seg)
            begin
                acc = acc + 14'(slopes[i*4 +: 4] * t[8:4]);
            end
        end
        // Saturate rather than wrap so the curve never jumps across the range
        if (invert)
        begin
            sum = {3'h0, base} - {1'b0, acc};
            blut_curve = sum[14] ? 12'h000 : sum[11:0];
        end
        else
        begin
            sum = {3'h0, base} + {1'b0, acc};
            blut_curve = (sum[14:12] != 3'h0) ? 12'hfff : sum[11:0];
        end
    endfunction

    blut_regs_t  r_reg;
    blut_regs_t  r_next;
    logic        writable;
    logic [11:0] base_a;
    logic [11:0] base_b;
    logic [11:0] temp_mux;

    // ==========================================================
    // Signal path
    assign writable = (r_reg.level == FULL_WRITE_ACCESS_LEVEL);
    assign base_a = {r_reg.wt[IDX_BASE_A_UP][3:0], r_reg.wt[IDX_BASE_A_LO]};
    assign base_b = {r_reg.wt[IDX_BASE_B_UP][3:0], r_reg.wt[IDX_BASE_B_LO]};
    // Host value replaces the sensor, LSB is 1/16 degree either way
    assign temp_mux = r_reg.ovr_sel[BIT_OVR_TEMP] ? r_reg.ovr_temp : r_reg.temp_held;

    // ==========================================================
    // Next state
    always_comb
    begin
        r_next = r_reg;
        // Pins pass two flops before use
        r_next.temp_s1 = sensor_temp;
        r_next.temp_s2 = r_reg.temp_s1;
        // A 12-bit word can tear in the synchroniser; take it once two samples agree
        r_next.temp_s3 = r_reg.temp_s2;
        if (r_reg.temp_s2 == r_reg.temp_s3)
        begin
            r_next.temp_held = r_reg.temp_s2;
        end
        r_next.en_s1 = {gate_drive_enable_b, gate_drive_enable_a};
        r_next.en_s2 = r_reg.en_s1;
        r_next.temp_used = temp_mux;
        // Curves from the live working table, bypass hands on the base code
        r_next.code_a = r_reg.wt[IDX_BASE_A_UP][BIT_BYPASS] ? base_a :
            blut_curve(base_a, {r_reg.wt[IDX_SLOPE_A+3], r_reg.wt[IDX_SLOPE_A+2],
                                r_reg.wt[IDX_SLOPE_A+1], r_reg.wt[IDX_SLOPE_A]},
                       r_reg.wt[IDX_BASE_A_UP][BIT_POLARITY], temp_mux);
        r_next.code_b = r_reg.wt[IDX_BASE_B_UP][BIT_BYPASS] ? base_b :
            blut_curve(base_b, {r_reg.wt[IDX_SLOPE_B+3], r_reg.wt[IDX_SLOPE_B+2],
                                r_reg.wt[IDX_SLOPE_B+1], r_reg.wt[IDX_SLOPE_B]},
                       r_reg.wt[IDX_BASE_B_UP][BIT_POLARITY], temp_mux);
        // Read mux, answer one cycle later; unmapped reads zero
        if (bus_req.rd)
        begin
            r_next.rdata = 8'h00;
            unique case (bus_req.addr)
                ADDR_ACCESS:     r_next.rdata = {6'h00, r_reg.level};
                ADDR_TEMP_UPPER: r_next.rdata = {4'h0, r_reg.temp_used[11:8]};
                ADDR_TEMP_LOWER: r_next.rdata = r_reg.temp_used[7:0];
                ADDR_CODEA_UP:   r_next.rdata = {4'h0, r_reg.code_a[11:8]};
                ADDR_CODEA_LO:   r_next.rdata = r_reg.code_a[7:0];
                ADDR_CODEB_UP:   r_next.rdata = {4'h0, r_reg.code_b[11:8]};
                ADDR_CODEB_LO:   r_next.rdata = r_reg.code_b[7:0];
                ADDR_OVR_SEL:    r_next.rdata = r_reg.ovr_sel;
                ADDR_OVR_T_UP:   r_next.rdata = {4'h0, r_reg.ovr_temp[11:8]};
                ADDR_OVR_T_LO:   r_next.rdata = r_reg.ovr_temp[7:0];
                ADDR_BURN_CNT:   r_next.rdata = r_reg.burn_cnt;
                ADDR_STATUS:     r_next.rdata = {6'h00, r_reg.st != ST_LOAD,
                                                 r_reg.st == ST_BURN};
                default:
                begin
                    if (bus_req.addr >= ADDR_TABLE &&
                        bus_req.addr <= ADDR_TABLE + 8'(TABLE_LAST))
                    begin
                        r_next.rdata = r_reg.wt[4'(bus_req.addr - ADDR_TABLE)];
                    end
                end
            endcase
        end
        // Access level is always settable; every other write needs full level
        if (bus_req.wr)
        begin
            if (bus_req.addr == ADDR_ACCESS)
            begin
                if (bus_req.wdata[7:2] == 6'h00 && bus_req.wdata[1:0] <= FULL_WRITE_ACCESS_LEVEL)
                begin
                    r_next.level = bus_req.wdata[1:0];
                end
            end
            else if (writable)
            begin
                unique case (bus_req.addr)
                    ADDR_OVR_SEL:  r_next.ovr_sel = bus_req.wdata;
                    ADDR_OVR_T_UP: r_next.ovr_temp[11:8] = bus_req.wdata[3:0];
                    ADDR_OVR_T_LO: r_next.ovr_temp[7:0] = bus_req.wdata;
                    ADDR_BURN_CMD:
                    begin
                        // A burn while loading or burning is dropped
                        if (bus_req.wdata[BIT_BURN_GO] && r_reg.st == ST_IDLE)
                        begin
                            r_next.st = ST_BURN;
                            r_next.idx = 4'h0;
                            if (r_reg.burn_cnt != BURN_CNT_MAX)
                            begin
                                r_next.burn_cnt = r_reg.burn_cnt + 8'h01;
                            end
                        end
                    end
                    default:
                    begin
                        // Table writes act at once, store untouched
                        if (r_reg.st != ST_LOAD && bus_req.addr >= ADDR_TABLE &&
                            bus_req.addr <= ADDR_TABLE + 8'(TABLE_LAST))
                        begin
                            r_next.wt[4'(bus_req.addr - ADDR_TABLE)] = bus_req.wdata;
                        end
                    end
                endcase
            end
        end
        // One table byte per cycle between working table and store
        unique case (r_reg.st)
            ST_LOAD:
            begin
                r_next.wt[r_reg.idx] = r_reg.nvm[r_reg.idx];
                r_next.idx = r_reg.idx + 4'h1;
                if (r_reg.idx == TABLE_LAST)
                begin
                    r_next.st = ST_IDLE;
                end
            end
            ST_BURN:
            begin
                r_next.nvm[r_reg.idx] = r_reg.wt[r_reg.idx];
                r_next.idx = r_reg.idx + 4'h1;
                if (r_reg.idx == TABLE_LAST)
                begin
                    r_next.st = ST_IDLE;
                end
            end
            ST_IDLE:
            begin
                // Walker parked at the first byte
                r_next.idx = 4'h0;
            end
        endcase
    end

    // ==========================================================
    // State register; reset here stands for power-up
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            r_reg <= '0;
            r_reg.st <= ST_LOAD;
            r_reg.level <= READ_ONLY_ACCESS_LEVEL;
            r_reg.nvm <= NVM_DEFAULT;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // ==========================================================
    // Outputs
    assign reg_rdata = r_reg.rdata;
    assign dac_code_a = r_reg.code_a;
    assign dac_code_b = r_reg.code_b;
    assign gate_drive_out_a = r_reg.en_s2[0];
    assign gate_drive_out_b = r_reg.en_s2[1];

    // ==========================================================
    // Checks
    AST_RESET_LEVEL: assert property (@(posedge clk)
        rst |=> r_reg.level == READ_ONLY_ACCESS_LEVEL)
        else $error("level not read-only after reset");

    AST_WRITE_NEEDS_LEVEL: assert property (@(posedge clk) disable iff (rst)
        bus_req.wr && bus_req.addr == ADDR_OVR_SEL && r_reg.level != FULL_WRITE_ACCESS_LEVEL
        |=> $stable(r_reg.ovr_sel))
        else $error("override select written below full level");

    AST_TABLE_LOCKED: assert property (@(posedge clk) disable iff (rst)
        r_reg.st == ST_IDLE && !writable |=> $stable(r_reg.wt))
        else $error("table changed below full level");

    AST_DRIVE_GATED: assert property (@(posedge clk) disable iff (rst)
        !gate_drive_enable_a [*3] |-> !gate_drive_out_a)
        else $error("drive a on with its enable low");

    AST_POWERUP_LOAD: assert property (@(posedge clk)
        rst ##1 !rst |-> ##[12:13] (r_reg.st == ST_IDLE && r_reg.wt == r_reg.nvm))
        else $error("working table not loaded at power-up");

    AST_STORE_HOLDS: assert property (@(posedge clk) disable iff (rst)
        r_reg.st != ST_BURN |=> $stable(r_reg.nvm))
        else $error("store changed without a burn");

    AST_BURN_COPY: assert property (@(posedge clk) disable iff (rst)
        r_reg.st == ST_IDLE && writable && bus_req.wr && bus_req.addr == ADDR_BURN_CMD &&
        bus_req.wdata[BIT_BURN_GO] |=> r_reg.st == ST_BURN ##12 r_reg.st == ST_IDLE)
        else $error("burn did not run over the whole table");

    AST_READ_TEMP: assert property (@(posedge clk) disable iff (rst)
        bus_req.rd && bus_req.addr == ADDR_TEMP_LOWER |=> reg_rdata == $past(r_reg.temp_used[7:0]))
        else $error("temperature lower read wrong");

    AST_OVERRIDE: assert property (@(posedge clk) disable iff (rst)
        r_reg.ovr_sel[BIT_OVR_TEMP] |=> r_reg.temp_used == $past(r_reg.ovr_temp))
        else $error("override temperature not used");

    AST_BYPASS_A: assert property (@(posedge clk) disable iff (rst)
        r_reg.wt[IDX_BASE_A_UP][BIT_BYPASS] |=> dac_code_a == $past(base_a))
        else $error("bypass did not pass base code");

    AST_BYPASS_B: assert property (@(posedge clk) disable iff (rst)
        r_reg.wt[IDX_BASE_B_UP][BIT_BYPASS] |=> dac_code_b == $past(base_b))
        else $error("bypass did not pass base code on b");

    AST_DRIVE_GATED_B: assert property (@(posedge clk) disable iff (rst)
        !gate_drive_enable_b [*3] |-> !gate_drive_out_b)
        else $error("drive b on with its enable low");

    AST_LOAD_DATA: assert property (@(posedge clk) disable iff (rst)
        r_reg.st == ST_LOAD |=> r_reg.wt[$past(r_reg.idx)] == $past(r_reg.nvm[r_reg.idx]))
        else $error("load byte not copied from the store");

    AST_BURN_DATA: assert property (@(posedge clk) disable iff (rst)
        r_reg.st == ST_BURN |=> r_reg.nvm[$past(r_reg.idx)] == $past(r_reg.wt[r_reg.idx]))
        else $error("burn byte not copied into the store");

    AST_FALLING_A: assert property (@(posedge clk) disable iff (rst)
        r_reg.wt[IDX_BASE_A_UP][BIT_POLARITY] && !r_reg.wt[IDX_BASE_A_UP][BIT_BYPASS]
        |=> dac_code_a <= $past(base_a))
        else $error("falling curve rose above its base");

    AST_SENSOR_SELECT: assert property (@(posedge clk) disable iff (rst)
        !r_reg.ovr_sel[BIT_OVR_TEMP] |=> r_reg.temp_used == $past(r_reg.temp_held))
        else $error("sensor temperature not used");
endmodule

// ---- test/blut_host_model.sv ----
// Host model: the bus bridge that drives the block's register port.
// Assumes the block answers a read in the cycle after the strobe.
`timescale 1ns/1ps
module blut_host_model
    import blut_pkg::*;
(
    // Clock
    input  wire logic       clk,
    // Register port
    output blut_bus_req_t   bus_req,
    input  wire logic [7:0] reg_rdata
);
    int burns;

    // ==========================================================
    // Idle port from time zero
    initial
    begin
        bus_req = '0;
        burns = 0;
    end

    // ==========================================================
    // One-cycle write strobe, launched just after an edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask

    // Read data stand from the cycle after the strobe until the next read
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // Writes other than to the access level only land once the full level is set
    task automatic unlock();
        wr(ADDR_ACCESS, {6'h00, FULL_WRITE_ACCESS_LEVEL});
    endtask

    // Store wears out, so burns past ten are withheld
    task automatic burn();
        if (burns < 10)
        begin
            burns++;
            wr(ADDR_BURN_CMD, 8'h01);
        end
    endtask
endmodule

// ---- test/testbench.sv ----
// Self-checking bench for the bias lookup table block.
// Assumes one 100 MHz clock and the host model on the register port.
`timescale 1ns/1ps
module testbench
    import blut_pkg::*;
;
    logic          clk;
    logic          rst;
    blut_bus_req_t bus_req;
    logic [7:0]    reg_rdata;
    logic [11:0]   sensor_temp;
    logic          gate_drive_enable_a;
    logic          gate_drive_enable_b;
    logic          gate_drive_out_a;
    logic          gate_drive_out_b;
    logic [11:0]   dac_code_a;
    logic [11:0]   dac_code_b;
    int            bad_count = 0;
    int            comparisons = 0;
    int            cycles = 0;

    // ==========================================================
    // Design and host
    blut_core u_dut (.clk(clk), .rst(rst), .bus_req(bus_req), .reg_rdata(reg_rdata),
        .sensor_temp(sensor_temp), .gate_drive_enable_a(gate_drive_enable_a),
        .gate_drive_enable_b(gate_drive_enable_b), .gate_drive_out_a(gate_drive_out_a),
        .gate_drive_out_b(gate_drive_out_b), .dac_code_a(dac_code_a),
        .dac_code_b(dac_code_b));
    blut_host_model u_host (.clk(clk), .bus_req(bus_req), .reg_rdata(reg_rdata));

    // 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Hang guard, well above the under two hundred cycles the run needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles > 3000)
        begin
            bad_count++;
            results();
        end
    end

    // ==========================================================
    // Compare and access helpers
    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        comparisons++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        u_host.rd(a, d);
        chk($sformatf("reg_%h", a), {4'h0, e}, {4'h0, d});
    endtask

    // Both codes through the registers and at the converter pins
    task automatic code(input logic [11:0] ea, input logic [11:0] eb);
        logic [7:0] u;
        logic [7:0] l;
        u_host.rd(ADDR_CODEA_UP, u);
        u_host.rd(ADDR_CODEA_LO, l);
        chk("code_a_regs", ea, {u[3:0], l});
        u_host.rd(ADDR_CODEB_UP, u);
        u_host.rd(ADDR_CODEB_LO, l);
        chk("code_b_regs", eb, {u[3:0], l});
        chk("dac_code_a", ea, dac_code_a);
        chk("dac_code_b", eb, dac_code_b);
    endtask

    // Polls a status bit under a bounded count
    task automatic wait_status(input int b, input logic v);
        logic [7:0] d;
        int n;
        n = 0;
        u_host.rd(ADDR_STATUS, d);
        while (d[b] !== v && n < 40)
        begin
            u_host.rd(ADDR_STATUS, d);
            n++;
        end
        chk("status_bit", {11'h000, v}, {11'h000, d[b]});
    endtask

    task automatic results();
        if (bad_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        rst = 1'b1;
        sensor_temp = 12'h234;
        gate_drive_enable_a = 1'b0;
        gate_drive_enable_b = 1'b0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc(ADDR_ACCESS, 8'h00);
        u_host.wr(ADDR_OVR_SEL, 8'h01);
        rdc(ADDR_OVR_SEL, 8'h00);
        rdc(ADDR_TEMP_LOWER, 8'h34);
        wait_status(BIT_LOADED, 1'b1);
        rdc(ADDR_TABLE, 8'h08);
        rdc(ADDR_TABLE + 8'h01, 8'h00);
        rdc(ADDR_TABLE + 8'h04, 8'h00);
        rdc(ADDR_TEMP_UPPER, 8'h02);
        // Level above the top one is refused
        u_host.wr(ADDR_ACCESS, 8'h03);
        rdc(ADDR_ACCESS, 8'h00);
        u_host.unlock();
        rdc(ADDR_ACCESS, 8'h02);
        rdc(8'h30, 8'h00);
        code(12'h800, 12'h800);
        // Host temperature 0x0f0, then steepest first slope
        u_host.wr(ADDR_OVR_T_UP, 8'h00);
        u_host.wr(ADDR_OVR_T_LO, 8'hf0);
        u_host.wr(ADDR_OVR_SEL, 8'h01);
        rdc(ADDR_TEMP_LOWER, 8'hf0);
        u_host.wr(ADDR_TABLE + 8'h04, 8'h0f);
        code(12'h8e1, 12'h800);
        // Segment boundary: full first segment, second slope zero
        u_host.wr(ADDR_OVR_T_UP, 8'h02);
        u_host.wr(ADDR_OVR_T_LO, 8'h00);
        code(12'h9e0, 12'h800);
        u_host.wr(ADDR_TABLE, 8'h88);
        code(12'h620, 12'h800);
        u_host.wr(ADDR_TABLE + 8'h01, 8'h34);
        u_host.wr(ADDR_TABLE, 8'h48);
        code(12'h834, 12'h800);
        // Back to the sensor
        u_host.wr(ADDR_OVR_SEL, 8'h00);
        rdc(ADDR_TEMP_LOWER, 8'h34);
        rdc(ADDR_TEMP_UPPER, 8'h02);
        rdc(ADDR_BURN_CNT, 8'h00);
        u_host.burn();
        rdc(ADDR_STATUS, 8'h03);
        wait_status(BIT_BUSY, 1'b0);
        rdc(ADDR_BURN_CNT, 8'h01);
        // Each enable gates only its own output
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            gate_drive_enable_a <= i[0];
            gate_drive_enable_b <= i[1];
            repeat (3) @(posedge clk);
            #1;
            chk("drive_a", {11'h000, i[0]}, {11'h000, gate_drive_out_a});
            chk("drive_b", {11'h000, i[1]}, {11'h000, gate_drive_out_b});
        end
        // Second power-up mid-run: level drops and the table reloads
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rdc(ADDR_ACCESS, 8'h00);
        wait_status(BIT_LOADED, 1'b1);
        rdc(ADDR_TABLE, 8'h08);
        results();
    end
endmodule
